// ==== design/usbsc_pkg.sv ====
// Purpose: Shared constants and carrier types for the USB status and control register block.
// Assumes: AHB-Lite register access, 32-bit words, one clock.
// Notes:   Offsets are byte addresses.
package usbsc_pkg;
  localparam logic [11:0] OFF_INTR_ENABLE  = 12'h084;
  localparam logic [11:0] OFF_ERROR_STATUS = 12'h088;
  localparam logic [11:0] OFF_ERROR_ENABLE = 12'h08C;
  localparam logic [11:0] OFF_TRANS_STATUS = 12'h090;
  localparam logic [11:0] OFF_CTRL         = 12'h094;
  localparam logic [11:0] OFF_FUNC_ADDR    = 12'h098;
  localparam logic [11:0] OFF_PRIMARY_FLAGS = 12'h080;

  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] ERROR_IMPL_MASK = 8'hBF;
  localparam int unsigned ERR_BTS   = 7;
  localparam int unsigned ERR_DMA   = 5;
  localparam int unsigned ERR_BTO   = 4;
  localparam int unsigned ERR_DFN   = 3;
  localparam int unsigned ERR_CRC16 = 2;
  localparam int unsigned ERR_CRC5  = 1;
  localparam int unsigned ERR_PID   = 0;
  localparam int unsigned FLG_TOKEN = 3;
  localparam int unsigned FLG_ERROR = 1;
  localparam int unsigned CTL_JSTATE = 7;
  localparam int unsigned CTL_SE0    = 6;
  localparam int unsigned CTL_BUSY   = 5;
  localparam int unsigned CTL_RESET  = 4;
  localparam int unsigned CTL_HOST   = 3;
  localparam int unsigned CTL_RESUME = 2;
  localparam int unsigned CTL_ODDRST = 1;
  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned ADR_LOWSPD = 7;

  localparam int unsigned BIT_TIME_NS    = 83;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TURNAROUND_BITS = 16;
  localparam int unsigned TURNAROUND_CYCLES = (TURNAROUND_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       stuffError;
    logic       memError;
    logic       dataLenError;
    logic       crc16Error;
    logic       crc5Error;
    logic       frameEndError;
    logic       pidError;
  } usbsc_err_evt_t;

  typedef struct packed {
    logic       done;
    logic [3:0] endpoint;
    logic       transmit;
    logic       oddBank;
  } usbsc_txn_t;

  typedef struct packed {
    logic       eopSeen;
    logic       busIdle;
    logic       lineDiffJ;
    logic       lineSe0;
  } usbsc_line_t;
endpackage : usbsc_pkg

// ==== design/usbsc_regs.sv ====
// Purpose: USB status and control registers reached over AHB-Lite.
// Assumes: Link engine reports events as one-cycle pulses in this clock domain.
// Notes:   Primary flags are kept here so the error summary and interrupt are local.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
// What this block does
// RULE1: Enable bits gate matching primary flags to interrupt.
// RULE2: Bit-stuff violation rejects packet, sets bit 7.
// RULE3: Underflow, overflow or oversize sets bit 5.
// RULE4: Over 16 idle bit times sets bit 4.
// RULE5: Data field not byte multiple sets bit 3.
// RULE6: CRC16 failure rejects packet, sets bit 2.
// RULE7: Token CRC5 or host frame-end sets bit 1.
// RULE8: PID check mismatch sets bit 0.
// RULE9: Error enables per bit; bit 6 reads zero.
// RULE10: Summary flag set by any recorded error whose enable bit is set.
// RULE11: Last token endpoint goes to bits 7:4.
// RULE12: Bit 3 transmit, bit 2 odd bank.
// RULE13: Clearing token-done clears or reloads status.
// RULE14: Bits 7,6 show live J and SE0.
// RULE15: Device SETUP sets busy and suspends tokens.
// RULE16: Host holds busy while a token runs.
// RULE17: Host drives bus reset while bit 4 set.
// RULE18: Bit 3 selects host, else device.
// RULE19: Resume while bit 2; host appends EOP.
// RULE20: Writing bit 1 clears all bank bits.
// RULE21: Enable bit resets banks; host generates SOF.
// RULE22: Address bit 7 makes next token low speed.
// RULE23: Bits 6:0 are matched or sent address.
// RULE24: Interrupt when flag and enable both set.
module usbsc_regs
  import usbsc_pkg::*;
(
  input  wire logic                     core_clk,        // System clock, 100 MHz.
  input  wire logic                     rst,             // Asynchronous reset, active high.
  input  wire logic                     hsel,            // AHB slave select.
  input  wire logic [11:0]              haddr,           // AHB byte address.
  input  wire logic [1:0]               htrans,          // AHB transfer type.
  input  wire logic                     hwrite,          // AHB write.
  input  wire logic [2:0]               hsize,           // AHB size.
  input  wire logic [31:0]              hwdata,          // AHB write data.
  input  wire logic                     hready,          // AHB bus ready.
  output logic      [31:0]              hrdata,          // AHB read data.
  output logic                          hreadyout,       // AHB slave ready.
  output logic                          hresp,           // AHB response, always OKAY.
  input  wire usbsc_pkg::usbsc_err_evt_t errEvent,       // Error pulses from the link engine.
  input  wire usbsc_pkg::usbsc_txn_t     txnEvent,       // Completed transaction report.
  input  wire usbsc_pkg::usbsc_line_t    lineState,      // Live receiver state.
  input  wire logic [7:0]               primarySet,      // Other primary flag pulses.
  input  wire logic                     setupSeen,       // SETUP token received.
  input  wire logic                     tokenStart,      // Host began a token.
  input  wire logic                     tokenEnd,        // Host finished a token.
  output logic                          usbIrq,          // Controller interrupt.
  output logic                          hostMode,        // Host operation selected.
  output logic                          controllerEnable, // Controller enabled.
  output logic                          tokenSuspend,    // Token processing held off.
  output logic                          busResetDrive,   // Drive USB reset signalling.
  output logic                          resumeDrive,     // Drive resume signalling.
  output logic                          lowSpeedEop,     // Append low-speed EOP pulse.
  output logic                          sofEnable,       // Generate start-of-frame packets.
  output logic                          bankClear,       // Clear all descriptor bank bits.
  output logic                          lowSpeedSelect,  // Next token at low speed.
  output logic [6:0]                    functionAddr     // Matched or sent address.
);
  import usbsc_pkg::*;

  logic [7:0] intrEnable, next_intrEnable;
  logic [7:0] errorStatus, next_errorStatus;
  logic [7:0] errorEnable, next_errorEnable;
  logic [7:0] primaryFlags, next_primaryFlags;
  logic [7:0] transStatus, next_transStatus;
  logic [7:0] heldStatus, next_heldStatus;
  logic       heldValid, next_heldValid;
  logic [7:0] ctrlReg, next_ctrlReg;
  logic [7:0] addrReg, next_addrReg;
  logic [11:0] wrAddr, next_wrAddr;
  logic        wrPend, next_wrPend;
  logic [31:0] next_hrdata;
  logic        next_usbIrq, next_bankClear, next_lowSpeedEop;
  logic [9:0]  idleCount, next_idleCount;
  logic        idleArmed, next_idleArmed;
  logic [7:0]  errSet;
  logic        addrPhase;
  logic [7:0]  wrByte;

  function automatic logic [7:0] usbsc_pack_status(input usbsc_txn_t t);
    usbsc_pack_status = {t.endpoint, t.transmit, t.oddBank, 2'b00};
  endfunction : usbsc_pack_status

  function automatic logic usbsc_hit(input logic [11:0] a, input logic [11:0] o);
    usbsc_hit = (a == o);
  endfunction : usbsc_hit

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wrByte    = hwdata[7:0];

  // Turnaround timer in clock cycles, armed by each end-of-packet.
  always_comb
  begin
    next_idleArmed = idleArmed;
    next_idleCount = idleCount;
    if (lineState.eopSeen)
    begin
      next_idleArmed = 1'b1;
      next_idleCount = '0;
    end
    else if (idleArmed && !lineState.busIdle)
    begin
      next_idleArmed = 1'b0;
    end
    else if (idleArmed && idleCount != 10'(TURNAROUND_CYCLES))
    begin
      next_idleCount = idleCount + 10'h001;
    end
    else if (idleArmed)
    begin
      next_idleArmed = 1'b0;
    end
  end

  always_comb
  begin
    errSet = 8'h00;
    errSet[ERR_BTS]   = errEvent.stuffError;                                  // RULE2
    errSet[ERR_DMA]   = errEvent.memError;                                    // RULE3
    errSet[ERR_BTO]   = idleArmed && lineState.busIdle &&
                        (idleCount == 10'(TURNAROUND_CYCLES));                // RULE4
    errSet[ERR_DFN]   = errEvent.dataLenError;                                // RULE5
    errSet[ERR_CRC16] = errEvent.crc16Error;                                  // RULE6
    errSet[ERR_CRC5]  = ctrlReg[CTL_HOST] ? errEvent.frameEndError
                                          : errEvent.crc5Error;               // RULE7
    errSet[ERR_PID]   = errEvent.pidError;                                    // RULE8
  end

  // Register state. Hardware sets always win over a software write in the same cycle.
  always_comb
  begin
    next_wrPend       = addrPhase && hwrite;
    next_wrAddr       = addrPhase ? haddr : wrAddr;
    next_intrEnable   = intrEnable;
    next_errorEnable  = errorEnable;
    next_errorStatus  = errorStatus;
    next_primaryFlags = primaryFlags;
    next_transStatus  = transStatus;
    next_heldStatus   = heldStatus;
    next_heldValid    = heldValid;
    next_ctrlReg      = ctrlReg;
    next_addrReg      = addrReg;
    next_bankClear    = 1'b0;
    next_lowSpeedEop  = 1'b0;
    if (wrPend)
    begin
      if (usbsc_hit(wrAddr, OFF_INTR_ENABLE))
        next_intrEnable = wrByte;                                             // RULE1
      if (usbsc_hit(wrAddr, OFF_ERROR_ENABLE))
        next_errorEnable = wrByte & ERROR_IMPL_MASK;                          // RULE9
      if (usbsc_hit(wrAddr, OFF_ERROR_STATUS))
        next_errorStatus = wrByte & ERROR_IMPL_MASK;
      if (usbsc_hit(wrAddr, OFF_PRIMARY_FLAGS))
      begin
        next_primaryFlags = primaryFlags & ~wrByte;
        if (wrByte[FLG_TOKEN] && primaryFlags[FLG_TOKEN])
        begin
          next_transStatus = heldValid ? heldStatus : RST_BYTE;               // RULE13
          next_primaryFlags[FLG_TOKEN] = heldValid;
          next_heldValid = 1'b0;
        end
      end
      if (usbsc_hit(wrAddr, OFF_CTRL))
      begin
        next_ctrlReg[CTL_BUSY:CTL_ENABLE] = wrByte[CTL_BUSY:CTL_ENABLE];      // RULE18
        next_bankClear = wrByte[CTL_ODDRST] ||
                         (wrByte[CTL_ENABLE] && !ctrlReg[CTL_ENABLE]);        // RULE20 RULE21
        next_lowSpeedEop = ctrlReg[CTL_HOST] && ctrlReg[CTL_RESUME] &&
                           !wrByte[CTL_RESUME];                               // RULE19
        next_ctrlReg[CTL_ODDRST] = 1'b0;
      end
      if (usbsc_hit(wrAddr, OFF_FUNC_ADDR))
        next_addrReg = wrByte;                                                // RULE22 RULE23
    end
    next_errorStatus = next_errorStatus | errSet;
    next_primaryFlags = next_primaryFlags | primarySet;
    // The incoming enable counts too, so enabling a pending error raises the summary at once.
    if (|(next_errorStatus & next_errorEnable))
      next_primaryFlags[FLG_ERROR] = 1'b1;                                    // RULE10 RULE24
    if (txnEvent.done)
    begin
      if (primaryFlags[FLG_TOKEN] && next_primaryFlags[FLG_TOKEN])
      begin
        next_heldStatus = usbsc_pack_status(txnEvent);
        next_heldValid  = 1'b1;
      end
      else
        next_transStatus = usbsc_pack_status(txnEvent);                       // RULE11 RULE12
      next_primaryFlags[FLG_TOKEN] = 1'b1;
    end
    if (!ctrlReg[CTL_HOST] && setupSeen)
      next_ctrlReg[CTL_BUSY] = 1'b1;                                          // RULE15
    if (ctrlReg[CTL_HOST] && tokenStart)
      next_ctrlReg[CTL_BUSY] = 1'b1;                                          // RULE16
    else if (ctrlReg[CTL_HOST] && tokenEnd)
      next_ctrlReg[CTL_BUSY] = 1'b0;
    next_ctrlReg[CTL_JSTATE] = lineState.lineDiffJ ^ addrReg[ADR_LOWSPD];     // RULE14
    next_ctrlReg[CTL_SE0]    = lineState.lineSe0;                             // RULE14
  end

  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    if (addrPhase && !hwrite)
    begin
      case (haddr)
        OFF_PRIMARY_FLAGS: next_hrdata[7:0] = primaryFlags;
        OFF_INTR_ENABLE:   next_hrdata[7:0] = intrEnable;
        OFF_ERROR_STATUS:  next_hrdata[7:0] = errorStatus;
        OFF_ERROR_ENABLE:  next_hrdata[7:0] = errorEnable;
        OFF_TRANS_STATUS:  next_hrdata[7:0] = transStatus;
        OFF_CTRL:          next_hrdata[7:0] = ctrlReg;
        OFF_FUNC_ADDR:     next_hrdata[7:0] = addrReg;
        default:           next_hrdata = 32'h0000_0000;
      endcase
    end
    next_usbIrq = |(primaryFlags & intrEnable);                               // RULE1 RULE24
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      intrEnable   <= RST_BYTE;
      errorStatus  <= RST_BYTE;
      errorEnable  <= RST_BYTE;
      primaryFlags <= RST_BYTE;
      transStatus  <= RST_BYTE;
      heldStatus   <= RST_BYTE;
      heldValid    <= 1'b0;
      ctrlReg      <= RST_BYTE;
      addrReg      <= RST_BYTE;
      wrAddr       <= 12'h000;
      wrPend       <= 1'b0;
      hrdata       <= 32'h0000_0000;
      usbIrq       <= 1'b0;
      bankClear    <= 1'b0;
      lowSpeedEop  <= 1'b0;
      idleCount    <= 10'h000;
      idleArmed    <= 1'b0;
    end
    else
    begin
      intrEnable   <= next_intrEnable;
      errorStatus  <= next_errorStatus;
      errorEnable  <= next_errorEnable;
      primaryFlags <= next_primaryFlags;
      transStatus  <= next_transStatus;
      heldStatus   <= next_heldStatus;
      heldValid    <= next_heldValid;
      ctrlReg      <= next_ctrlReg;
      addrReg      <= next_addrReg;
      wrAddr       <= next_wrAddr;
      wrPend       <= next_wrPend;
      hrdata       <= next_hrdata;
      usbIrq       <= next_usbIrq;
      bankClear    <= next_bankClear;
      lowSpeedEop  <= next_lowSpeedEop;
      idleCount    <= next_idleCount;
      idleArmed    <= next_idleArmed;
    end
  end

  // Zero-wait slave: every transfer completes in its first data-phase cycle.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Control outputs are registered copies so they stay glitch free at the pins.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hostMode         <= 1'b0;
      controllerEnable <= 1'b0;
      tokenSuspend     <= 1'b0;
      busResetDrive    <= 1'b0;
      resumeDrive      <= 1'b0;
      sofEnable        <= 1'b0;
      lowSpeedSelect   <= 1'b0;
      functionAddr     <= 7'h00;
    end
    else
    begin
      hostMode         <= next_ctrlReg[CTL_HOST];                             // RULE18
      controllerEnable <= next_ctrlReg[CTL_ENABLE];
      tokenSuspend     <= next_ctrlReg[CTL_BUSY];                             // RULE15
      busResetDrive    <= next_ctrlReg[CTL_RESET] && next_ctrlReg[CTL_HOST];  // RULE17
      resumeDrive      <= next_ctrlReg[CTL_RESUME];                           // RULE19
      sofEnable        <= next_ctrlReg[CTL_ENABLE] && next_ctrlReg[CTL_HOST]; // RULE21
      lowSpeedSelect   <= next_addrReg[ADR_LOWSPD];                           // RULE22
      functionAddr     <= next_addrReg[6:0];                                  // RULE23
    end
  end

  sequence usbsc_ctrl_write_s;
    wrPend && usbsc_hit(wrAddr, OFF_CTRL);
  endsequence

  chk_irq_gating: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    |(primaryFlags & intrEnable) |=> usbIrq)
    else $error("Interrupt does not follow flags and enables.");
  chk_irq_quiet: assert property (@(posedge core_clk) disable iff (rst) // RULE24
    !(|(primaryFlags & intrEnable)) |=> !usbIrq)
    else $error("Interrupt without enabled flag.");
  chk_bts_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    errEvent.stuffError |=> errorStatus[ERR_BTS])
    else $error("Bit stuff error not recorded.");
  chk_dma_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    errEvent.memError |=> errorStatus[ERR_DMA])
    else $error("Memory error not recorded.");
  chk_dfn_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    errEvent.dataLenError |=> errorStatus[ERR_DFN])
    else $error("Data length error not recorded.");
  chk_crc16_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    errEvent.crc16Error |=> errorStatus[ERR_CRC16])
    else $error("CRC16 error not recorded.");
  chk_crc5_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    (!ctrlReg[CTL_HOST] && errEvent.crc5Error) |=> errorStatus[ERR_CRC5])
    else $error("Token CRC error not recorded.");
  chk_pid_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    errEvent.pidError |=> errorStatus[ERR_PID])
    else $error("PID error not recorded.");
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    !errorEnable[6] && !errorStatus[6])
    else $error("Reserved error bit is set.");
  chk_summary_flag: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    |(errorStatus & errorEnable) |-> primaryFlags[FLG_ERROR])
    else $error("Error summary flag missing.");
  chk_setup_busy: assert property (@(posedge core_clk) disable iff (rst) // RULE15
    (!ctrlReg[CTL_HOST] && setupSeen) |=> ctrlReg[CTL_BUSY] && tokenSuspend)
    else $error("SETUP did not suspend tokens.");
  chk_bank_clear: assert property (@(posedge core_clk) disable iff (rst) // RULE20
    (usbsc_ctrl_write_s and wrByte[CTL_ODDRST]) |=> bankClear ##1 !ctrlReg[CTL_ODDRST])
    else $error("Bank clear pulse missing.");
  chk_bto_sets: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    (idleArmed && lineState.busIdle && idleCount == 10'(TURNAROUND_CYCLES))
    |=> errorStatus[ERR_BTO])
    else $error("Turnaround timeout not recorded.");
  chk_bus_reset: assert property (@(posedge core_clk) disable iff (rst) // RULE17
    busResetDrive == (ctrlReg[CTL_RESET] && ctrlReg[CTL_HOST]))
    else $error("Bus reset drive wrong.");
  chk_host_busy: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    (ctrlReg[CTL_HOST] && tokenStart) |=> ctrlReg[CTL_BUSY])
    else $error("Host token did not set busy.");
  chk_txn_record: assert property (@(posedge core_clk) disable iff (rst) // RULE11 RULE12
    (txnEvent.done && !primaryFlags[FLG_TOKEN]) |=>
    transStatus[7:3] == {$past(txnEvent.endpoint), $past(txnEvent.transmit)})
    else $error("Transaction status not recorded.");
  chk_sof_enable: assert property (@(posedge core_clk) disable iff (rst) // RULE21
    sofEnable == (ctrlReg[CTL_ENABLE] && ctrlReg[CTL_HOST]))
    else $error("Frame generation enable wrong.");
  chk_addr_copy: assert property (@(posedge core_clk) disable iff (rst) // RULE22 RULE23
    {lowSpeedSelect, functionAddr} == addrReg)
    else $error("Address outputs wrong.");
endmodule : usbsc_regs

// ==== test/usbsc_link_model.sv ====
// Purpose: Link engine stand-in that raises the register block's event inputs.
// Assumes: Each call starts just after a rising edge; pulses last one clock.
// Notes:   Line levels are held until the next line call changes them.
`timescale 1ns/10ps
module usbsc_link_model
  import usbsc_pkg::*;
(
  input  wire logic                 core_clk,   // System clock.
  output usbsc_pkg::usbsc_err_evt_t errEvent,   // Error pulses.
  output usbsc_pkg::usbsc_txn_t     txnEvent,   // Transaction report.
  output usbsc_pkg::usbsc_line_t    lineState,  // Receiver state.
  output logic [7:0]                primarySet, // Primary flag pulses.
  output logic [2:0]                tokEvt      // Setup, start and end pulses.
);
  initial
  begin
    errEvent = '0;
    txnEvent = '0;
    lineState = '0;
    primarySet = '0;
    tokEvt = '0;
  end

  // The extra edge keeps a following call from landing on the clearing edge.
  task automatic ev(input logic [6:0] e, input logic [7:0] p, input logic [2:0] t, input usbsc_txn_t x);
    errEvent <= e;
    primarySet <= p;
    tokEvt <= t;
    txnEvent <= x;
    @(posedge core_clk);
    errEvent <= '0;
    primarySet <= '0;
    tokEvt <= '0;
    txnEvent <= '0;
    @(posedge core_clk);
  endtask : ev

  task automatic line(input logic j, input logic se0, input logic idle, input logic eop);
    lineState <= '{eop, idle, j, se0};
    @(posedge core_clk);
    lineState.eopSeen <= 1'b0;
    @(posedge core_clk);
  endtask : line
endmodule : usbsc_link_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the USB status and control registers.
// Assumes: Zero-wait AHB slave; link events come from the link model.
// Notes:   Pulsed outputs are counted; levels are sampled after a settle or a register read.
`timescale 1ns/10ps
module tb_top;
  import usbsc_pkg::*;
  logic           core_clk;
  logic           rst;
  logic [11:0]    haddr;
  logic [1:0]     htrans;
  logic           hwrite;
  logic [31:0]    hwdata;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  usbsc_err_evt_t errEvent;
  usbsc_txn_t     txnEvent;
  usbsc_line_t    lineState;
  logic [7:0]     primarySet;
  logic [2:0]     tokEvt;
  logic [7:0]     lv;
  logic           lowSpeedEop;
  logic           bankClear;
  logic [6:0]     functionAddr;
  int             num_errors;
  int             n_checks;
  int             cyc;
  int             eopCnt;
  int             bankCnt;

  usbsc_link_model link_u (.core_clk(core_clk), .errEvent(errEvent), .txnEvent(txnEvent),
    .lineState(lineState), .primarySet(primarySet), .tokEvt(tokEvt));
  usbsc_regs dut_u (.core_clk(core_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .errEvent(errEvent), .txnEvent(txnEvent),
    .lineState(lineState), .primarySet(primarySet), .setupSeen(tokEvt[2]), .tokenStart(tokEvt[1]),
    .tokenEnd(tokEvt[0]), .usbIrq(lv[7]), .hostMode(lv[6]), .controllerEnable(lv[5]),
    .tokenSuspend(lv[4]), .busResetDrive(lv[3]), .resumeDrive(lv[2]), .lowSpeedEop(lowSpeedEop),
    .sofEnable(lv[1]), .bankClear(bankClear), .lowSpeedSelect(lv[0]), .functionAddr(functionAddr));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    eopCnt <= eopCnt + int'(lowSpeedEop);
    bankCnt <= bankCnt + int'(bankClear);
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // One single transfer; a slave that never answers is caught by the cycle ceiling.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e, m);
  endtask : rdchk

  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic t_reset;
    logic [11:0] a[7] = '{OFF_INTR_ENABLE, OFF_ERROR_STATUS, OFF_ERROR_ENABLE, OFF_TRANS_STATUS,
                          OFF_CTRL, OFF_FUNC_ADDR, 12'h0A0};
    wr(OFF_TRANS_STATUS, 32'hFF);
    wr(12'h0A0, 32'hFF);
    foreach (a[i])
      rdchk(a[i], 32'h0, "reset value");
    chk(32'({lv, hresp, hreadyout}), 32'h1, "idle outputs and response");
    $display("test reset done");
  endtask : t_reset

  task automatic t_errors;
    int src[6] = '{6, 5, 4, 3, 2, 0};
    int dst[6] = '{7, 5, 3, 2, 1, 0};
    foreach (src[i])
    begin
      link_u.ev(7'(1 << src[i]), 8'h0, 3'h0, '0);
      rdchk(OFF_ERROR_STATUS, 32'(1 << dst[i]), "error flag");
      wr(OFF_ERROR_STATUS, 32'h0);
    end
    rdchk(OFF_PRIMARY_FLAGS, 32'h0, "summary masked");
    wr(OFF_ERROR_ENABLE, 32'hFF);
    rdchk(OFF_ERROR_ENABLE, 32'hBF, "enable bits");
    link_u.ev(7'h01, 8'h0, 3'h0, '0);
    rdchk(OFF_PRIMARY_FLAGS, 32'h2, "summary set");
    wr(OFF_INTR_ENABLE, 32'h2);
    settle();
    chk(32'(lv[7]), 32'h1, "error irq");
    wr(OFF_ERROR_STATUS, 32'h0);
    wr(OFF_ERROR_ENABLE, 32'h0);
    wr(OFF_PRIMARY_FLAGS, 32'hFF);
    wr(OFF_INTR_ENABLE, 32'h0);
    $display("test errors done");
  endtask : t_errors

  task automatic t_irq;
    for (int i = 0; i < 8; i++)
    begin
      wr(OFF_INTR_ENABLE, 32'(~(8'h1 << i)));
      link_u.ev(7'h0, 8'h1 << i, 3'h0, '0);
      settle();
      chk(32'(lv[7]), 32'h0, "masked flag");
      wr(OFF_INTR_ENABLE, 32'h1 << i);
      settle();
      chk(32'(lv[7]), 32'h1, "enabled flag");
      wr(OFF_PRIMARY_FLAGS, 32'hFF);
    end
    wr(OFF_INTR_ENABLE, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_txn;
    link_u.ev(7'h0, 8'h0, 3'h0, '{1'b1, 4'hF, 1'b1, 1'b1});
    rdchk(OFF_TRANS_STATUS, 32'hFC, "txn status");
    link_u.ev(7'h0, 8'h0, 3'h0, '{1'b1, 4'h3, 1'b0, 1'b0});
    rdchk(OFF_TRANS_STATUS, 32'hFC, "held status");
    wr(OFF_PRIMARY_FLAGS, 32'h08);
    rdchk(OFF_TRANS_STATUS, 32'h30, "reloaded status");
    wr(OFF_PRIMARY_FLAGS, 32'h08);
    rdchk(OFF_TRANS_STATUS, 32'h0, "cleared status");
    $display("test txn done");
  endtask : t_txn

  task automatic t_ctrl;
    int b;
    link_u.ev(7'h0, 8'h0, 3'h4, '0);
    rdchk(OFF_CTRL, 32'h20, "setup busy");
    chk(32'(lv[4]), 32'h1, "suspend");
    wr(OFF_CTRL, 32'h10);
    settle();
    chk(32'(lv[4:3]), 32'h0, "device no reset");
    b = bankCnt;
    wr(OFF_CTRL, 32'h09);
    settle();
    chk(32'(lv[6:5]), 32'h3, "host enable");
    chk(32'(lv[1]), 32'h1, "sof enable");
    chk(bankCnt - b, 32'h1, "enable bank clear");
    wr(OFF_CTRL, 32'h0B);
    settle();
    rdchk(OFF_CTRL, 32'h09, "odd reset self clears");
    chk(bankCnt - b, 32'h2, "odd reset");
    wr(OFF_CTRL, 32'h19);
    settle();
    chk(32'(lv[3]), 32'h1, "bus reset");
    b = eopCnt;
    wr(OFF_CTRL, 32'h0D);
    settle();
    chk(32'(lv[3:2]), 32'h1, "resume");
    wr(OFF_CTRL, 32'h09);
    settle();
    chk(eopCnt - b, 32'h1, "low speed eop");
    link_u.ev(7'h0, 8'h0, 3'h2, '0);
    rdchk(OFF_CTRL, 32'h29, "host busy");
    link_u.ev(7'h0, 8'h0, 3'h1, '0);
    rdchk(OFF_CTRL, 32'h09, "host idle");
    link_u.ev(7'h02, 8'h0, 3'h0, '0);
    rdchk(OFF_ERROR_STATUS, 32'h02, "frame end");
    wr(OFF_ERROR_STATUS, 32'h0);
    link_u.line(1'b1, 1'b0, 1'b1, 1'b0);
    rdchk(OFF_CTRL, 32'h89, "live j");
    wr(OFF_FUNC_ADDR, 32'hD5);
    settle();
    rdchk(OFF_CTRL, 32'h09, "j low speed");
    chk(32'(lv[0]), 32'h1, "low speed");
    chk(32'(functionAddr), 32'h55, "address");
    link_u.line(1'b0, 1'b1, 1'b0, 1'b0);
    rdchk(OFF_CTRL, 32'hC9, "live se0");
    wr(OFF_CTRL, 32'h0);
    wr(OFF_FUNC_ADDR, 32'h0);
    $display("test ctrl done");
  endtask : t_ctrl

  // A short idle must not count, so the long case proves the threshold.
  task automatic t_turn;
    link_u.line(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (TURNAROUND_CYCLES / 2) @(posedge core_clk);
    link_u.line(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (TURNAROUND_CYCLES + 10) @(posedge core_clk);
    rdchk(OFF_ERROR_STATUS, 32'h0, "short idle");
    link_u.line(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (TURNAROUND_CYCLES + 10) @(posedge core_clk);
    rdchk(OFF_ERROR_STATUS, 32'h10, "turnaround");
    $display("test turn done");
  endtask : t_turn

  initial
  begin
    rst = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_errors();
    t_irq();
    t_txn();
    t_ctrl();
    t_turn();
    report_and_stop();
  end
endmodule : tb_top
